// File: inc/adc_pfs_pkg.sv
package adc_pfs_pkg;
    localparam int CH_W = 4;
    localparam int DATA_W = 10;
    localparam int THR_W = 8;
    localparam int EVT_W = 2;
    localparam int NUM_CH = 12;
    localparam logic [CH_W-1:0] LAST_CH = 4'hb;
    // Register byte addresses
    localparam logic [7:0] OFS_MODE = 8'h00;
    localparam logic [7:0] OFS_CHSEL = 8'h04;
    localparam logic [7:0] OFS_THRESH = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0c;
    localparam logic [7:0] OFS_MASK = 8'h10;
    localparam logic [7:0] OFS_STATE = 8'h14;
    localparam logic [7:0] OFS_RESULT = 8'h40;
    // Field positions
    localparam int EVT_MATCH_BIT = 0;
    localparam int EVT_WRAP_BIT = 1;
    // Values after reset
    localparam logic [2:0] MODE_RST = 3'h0;
    localparam logic [CH_W-1:0] CHSEL_RST = 4'h0;
    localparam logic [THR_W-1:0] THRESH_RST = 8'h00;
    localparam logic [EVT_W-1:0] MASK_RST = 2'h0;
    localparam logic [EVT_W-1:0] STATUS_RST = 2'h0;
    // Read answer timing in cycles
    localparam logic [1:0] RD_LOAD = 2'h1;
    localparam logic [1:0] RD_DONE = 2'h2;

    typedef struct packed {
        logic cond;
        logic scan;
        logic enable;
    } mode_s;

    typedef struct packed {
        logic [CH_W-1:0] ch;
        logic [DATA_W-1:0] data;
    } result_s;

    typedef enum logic [1:0] {st_idle, st_issue, st_wait} seq_e;
endpackage

// File: hw/result_mem.sv
`timescale 1ns/1ns
module result_mem
    import adc_pfs_pkg::*;
(
    // Clock
    input wire logic mclk,
    // Write side
    input wire logic we,
    input wire result_s wr,
    // Read side
    input wire logic [CH_W-1:0] raddr,
    output logic [DATA_W-1:0] rdata
);
    logic [DATA_W-1:0] mem [NUM_CH];

    // No reset: results read as unknown until first stored
    always_ff @(posedge mclk) begin
        if (we && wr.ch <= LAST_CH) begin
            mem[wr.ch] <= wr.data;
        end
        rdata <= (raddr <= LAST_CH) ? mem[raddr] : '0;
    end
endmodule

// File: hw/irq_ctrl.sv
`timescale 1ns/1ns
module irq_ctrl
    import adc_pfs_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Events and software side
    input wire logic [EVT_W-1:0] set,
    input wire logic clear,
    input wire logic [EVT_W-1:0] mask,
    // Outputs
    output logic [EVT_W-1:0] status,
    output logic irq
);
    logic [EVT_W-1:0] next_status;
    logic next_irq;

    // An event in the clearing cycle survives the read
    always_comb begin
        next_status = (status & ~{EVT_W{clear}}) | set;
        next_irq = |(next_status & mask);
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            status <= STATUS_RST;
            irq <= 1'b0;
        end else begin
            status <= next_status;
            irq <= next_irq;
        end
    end
endmodule

// File: hw/adc_power_fail_sequencer.sv
`timescale 1ns/1ns
module adc_power_fail_sequencer
    import adc_pfs_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Avalon-MM slave
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Converter front end
    output logic conv_start,
    output logic [CH_W-1:0] conv_channel,
    input wire logic conv_done,
    input wire logic [DATA_W-1:0] conv_data,
    // Interrupts
    output logic conversion_done_irq,
    output logic irq
);
    function automatic logic meets(input logic [THR_W-1:0] hi,
                                   input logic [THR_W-1:0] thr,
                                   input logic cond);
        meets = cond ? (hi < thr) : (hi >= thr);
    endfunction

    function automatic logic is_result(input logic [7:0] a);
        is_result = (a[7:6] == OFS_RESULT[7:6]) && (a[1:0] == 2'h0) &&
                    (a[5:2] <= LAST_CH);
    endfunction

    mode_s mode;
    mode_s next_mode;
    logic [CH_W-1:0] chsel;
    logic [CH_W-1:0] next_chsel;
    logic [THR_W-1:0] thresh;
    logic [THR_W-1:0] next_thresh;
    logic [EVT_W-1:0] mask;
    logic [EVT_W-1:0] next_mask;
    logic [EVT_W-1:0] status;
    logic [1:0] rd_cnt;
    logic [1:0] next_rd_cnt;
    logic [31:0] next_readdata;
    logic [31:0] rd_mux;
    logic [DATA_W-1:0] mem_q;
    logic rd_take;
    logic status_clear;
    logic wr_hit;
    seq_e state;
    seq_e next_state;
    logic [CH_W-1:0] next_channel;
    logic [CH_W-1:0] eff_last;
    logic [THR_W-1:0] hi;
    logic done_now;
    logic cmp_ch;
    logic match_evt;
    logic wrap_evt;
    result_s wr;

    // Register writes; only byte lane 0 carries bits
    assign wr_hit = write && byteenable[0];

    always_comb begin
        next_mode = mode;
        next_chsel = chsel;
        next_thresh = thresh;
        next_mask = mask;
        if (wr_hit) begin
            case (address)
                OFS_MODE: next_mode = mode_s'(writedata[2:0]);
                OFS_CHSEL: next_chsel = writedata[CH_W-1:0];
                OFS_THRESH: next_thresh = writedata[THR_W-1:0];
                OFS_MASK: next_mask = writedata[EVT_W-1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            mode <= mode_s'(MODE_RST);
            chsel <= CHSEL_RST;
            thresh <= THRESH_RST;
            mask <= MASK_RST;
        end else begin
            mode <= next_mode;
            chsel <= next_chsel;
            thresh <= next_thresh;
            mask <= next_mask;
        end
    end

    // Reads take two wait cycles so the result memory can answer
    assign waitrequest = read && (rd_cnt != RD_DONE);
    assign rd_take = read && (rd_cnt == RD_DONE);
    assign status_clear = rd_take && (address == OFS_STATUS);

    always_comb begin
        rd_mux = 32'h0;
        if (is_result(address)) begin
            rd_mux = {22'h0, mem_q};
        end else begin
            case (address)
                OFS_MODE: rd_mux = {29'h0, mode};
                OFS_CHSEL: rd_mux = {28'h0, chsel};
                OFS_THRESH: rd_mux = {24'h0, thresh};
                OFS_STATUS: rd_mux = {30'h0, status};
                OFS_MASK: rd_mux = {30'h0, mask};
                OFS_STATE: rd_mux = {24'h0, conv_channel, 3'h0,
                                     state != st_idle};
                default: rd_mux = 32'h0;
            endcase
        end
    end

    always_comb begin
        next_rd_cnt = 2'h0;
        next_readdata = readdata;
        if (read && rd_cnt != RD_DONE) begin
            next_rd_cnt = rd_cnt + 2'h1;
        end
        if (read && rd_cnt == RD_LOAD) begin
            next_readdata = rd_mux;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rd_cnt <= 2'h0;
            readdata <= 32'h0;
        end else begin
            rd_cnt <= next_rd_cnt;
            readdata <= next_readdata;
        end
    end

    // Sequencer; a select value past the last input acts as the last
    assign eff_last = (chsel > LAST_CH) ? LAST_CH : chsel;
    assign done_now = (state == st_wait) && conv_done;
    assign hi = conv_data[DATA_W-1 -: THR_W];
    assign cmp_ch = !mode.scan || (conv_channel == '0);
    assign match_evt = done_now && cmp_ch && meets(hi, thresh, mode.cond);
    assign wrap_evt = done_now && mode.scan && (conv_channel >= eff_last);
    assign conversion_done_irq = match_evt;
    assign conv_start = (state == st_issue);

    always_comb begin
        next_state = state;
        next_channel = conv_channel;
        unique case (state)
            st_idle: begin
                if (mode.enable) begin
                    next_state = st_issue;
                    next_channel = mode.scan ? '0 : eff_last;
                end
            end
            st_issue: next_state = st_wait;
            st_wait: begin
                if (conv_done) begin
                    if (!mode.enable) begin
                        next_state = st_idle;
                    end else begin
                        next_state = st_issue;
                        if (!mode.scan) begin
                            next_channel = eff_last;
                        end else if (conv_channel >= eff_last) begin
                            next_channel = '0;
                        end else begin
                            next_channel = conv_channel + 4'h1;
                        end
                    end
                end
            end
            default: next_state = st_idle;
        endcase
    end

    // A conversion in flight when enable drops still completes
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state <= st_idle;
            conv_channel <= '0;
        end else begin
            state <= next_state;
            conv_channel <= next_channel;
        end
    end

    assign wr = '{ch: conv_channel, data: conv_data};

    result_mem u_mem (
        .mclk(mclk),
        .we(done_now),
        .wr(wr),
        .raddr(address[5:2]),
        .rdata(mem_q)
    );

    // raise interrupt on match or wrap, as enabled in mask
    // Next mask, so irq follows a mask write with no stale cycle
    irq_ctrl u_irq (
        .mclk(mclk),
        .rst(rst),
        .set({wrap_evt, match_evt}),
        .clear(status_clear),
        .mask(next_mask),
        .status(status),
        .irq(irq)
    );

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    property p_sel_channel;
        conv_start && !mode.scan && $stable(chsel) |->
            conv_channel == eff_last;
    endproperty
    a_sel_channel: assert property (p_sel_channel)
        else $error("select mode converts wrong channel");

    property p_sel_irq;
        done_now && !mode.scan && meets(hi, thresh, mode.cond) |=>
            status[EVT_MATCH_BIT];
    endproperty
    a_sel_irq: assert property (p_sel_irq)
        else $error("select match did not set status");

    property p_no_irq;
        done_now && !meets(hi, thresh, mode.cond) && !status_clear &&
            !status[EVT_MATCH_BIT] |=> !status[EVT_MATCH_BIT];
    endproperty
    a_no_irq: assert property (p_no_irq)
        else $error("mismatch raised the interrupt");

    property p_repeat;
        done_now && mode.enable |=> conv_start ##1 state == st_wait;
    endproperty
    a_repeat: assert property (p_repeat)
        else $error("next conversion not started");

    property p_stop;
        done_now && !mode.enable |=> state == st_idle ##1 !conv_start;
    endproperty
    a_stop: assert property (p_stop)
        else $error("conversion continued after disable");

    property p_scan_start;
        state == st_idle && mode.enable && mode.scan |=>
            conv_start && conv_channel == '0;
    endproperty
    a_scan_start: assert property (p_scan_start)
        else $error("scan did not start at input zero");

    property p_scan_cmp;
        done_now && mode.scan && conv_channel != '0 && !status_clear &&
            !status[EVT_MATCH_BIT] |=> !status[EVT_MATCH_BIT];
    endproperty
    a_scan_cmp: assert property (p_scan_cmp)
        else $error("scan compared a channel other than zero");

    property p_scan_irq;
        done_now && mode.scan && conv_channel == '0 &&
            meets(hi, thresh, mode.cond) |=> status[EVT_MATCH_BIT];
    endproperty
    a_scan_irq: assert property (p_scan_irq)
        else $error("scan channel zero match lost");

    property p_scan_step;
        done_now && mode.enable && mode.scan && conv_channel < eff_last
            |=> conv_start && conv_channel == $past(conv_channel) + 4'h1;
    endproperty
    a_scan_step: assert property (p_scan_step)
        else $error("scan skipped a channel");

    property p_scan_wrap;
        done_now && mode.enable && mode.scan && conv_channel >= eff_last
            |=> conv_start && conv_channel == '0;
    endproperty
    a_scan_wrap: assert property (p_scan_wrap)
        else $error("scan did not wrap to input zero");

    c_sel_match: cover property (match_evt && !mode.scan);
    c_scan_wrap: cover property (wrap_evt ##[1:40] match_evt);
    c_clear: cover property (status_clear && status[EVT_MATCH_BIT]);
endmodule

// File: verification/adc_power_fail_sequencer_tb.sv
`timescale 1ns/1ns
module adc_power_fail_sequencer_tb
    import adc_pfs_pkg::*;
;
    logic mclk, rst, read, write, conv_done;
    logic [7:0] address;
    logic [31:0] writedata, readdata, q;
    logic [3:0] byteenable;
    logic waitrequest, conv_start, conversion_done_irq, irq;
    logic [CH_W-1:0] conv_channel;
    logic [DATA_W-1:0] conv_data;
    int mismatches, checks;

    adc_power_fail_sequencer adc_power_fail_sequencer_inst (
        .mclk(mclk),
        .rst(rst),
        .address(address),
        .read(read),
        .write(write),
        .writedata(writedata),
        .byteenable(byteenable),
        .readdata(readdata),
        .waitrequest(waitrequest),
        .conv_start(conv_start),
        .conv_channel(conv_channel),
        .conv_done(conv_done),
        .conv_data(conv_data),
        .conversion_done_irq(conversion_done_irq),
        .irq(irq)
    );

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask

    // Request held until waitrequest is seen low; taken at the next edge
    task automatic acc(input logic is_rd, input logic [7:0] a,
                       input logic [31:0] d, input logic [3:0] be);
        int n;
        n = 0;
        @(posedge mclk);
        address <= a;
        read <= is_rd;
        write <= !is_rd;
        writedata <= d;
        byteenable <= be;
        #1;
        while (waitrequest !== 1'b0 && n < 50) begin
            @(posedge mclk);
            #1;
            n++;
        end
        if (n == 50) mismatches++;
        q = readdata;
        @(posedge mclk);
        read <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        acc(1'b0, a, d, 4'h1);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        acc(1'b1, a, 32'h0, 4'h0);
        chk(q, e);
    endtask

    task automatic catch_start(input logic [CH_W-1:0] ch);
        int n;
        n = 0;
        #1;
        while (conv_start !== 1'b1 && n < 50) begin
            @(posedge mclk);
            #1;
            n++;
        end
        if (n == 50) mismatches++;
        chk(32'(conv_channel), 32'(ch));
    endtask

    // Converter answers two cycles after the start pulse
    task automatic fin(input logic [DATA_W-1:0] d, input logic e);
        repeat (2) @(posedge mclk);
        conv_done <= 1'b1;
        conv_data <= d;
        #1;
        chk(32'(conversion_done_irq), 32'(e));
        @(posedge mclk);
        conv_done <= 1'b0;
        conv_data <= ~d;
    endtask

    task automatic irq_chk(input logic e);
        @(posedge mclk);
        #1;
        chk(32'(irq), 32'(e));
    endtask

    task automatic idle_chk();
        int n;
        n = 0;
        repeat (30) begin
            #1;
            if (conv_start !== 1'b0) n++;
            @(posedge mclk);
        end
        chk(32'(n), 32'h0);
    endtask

    initial begin
        #(40 * 20000);
        mismatches++;
        conclude();
    end

    initial begin
        rst = 1'b1;
        read = 1'b0;
        write = 1'b0;
        address = 8'h00;
        writedata = 32'h0;
        byteenable = 4'h0;
        conv_done = 1'b0;
        conv_data = 10'h000;
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        rd(OFS_MODE, 32'h0);
        rd(OFS_CHSEL, 32'h0);
        rd(OFS_THRESH, 32'h0);
        rd(OFS_STATUS, 32'h0);
        rd(OFS_MASK, 32'h0);
        rd(OFS_STATE, 32'h0);
        // Refused writes: lane off, unmapped, read-only
        acc(1'b0, OFS_THRESH, 32'h55, 4'h0);
        rd(OFS_THRESH, 32'h0);
        wr(8'h30, 32'h3);
        rd(8'h30, 32'h0);
        wr(OFS_STATUS, 32'h3);
        rd(OFS_STATUS, 32'h0);
        // Select mode on input one
        wr(OFS_THRESH, 32'h80);
        wr(OFS_MASK, 32'h1);
        wr(OFS_CHSEL, 32'h1);
        wr(OFS_MODE, 32'h1);
        catch_start(4'h1);
        fin(10'h200, 1'b1);
        catch_start(4'h1);
        irq_chk(1'b1);
        fin(10'h1fc, 1'b0);
        catch_start(4'h1);
        rd(OFS_RESULT + 8'h04, 32'h1fc);
        rd(OFS_STATE, 32'h11);
        rd(OFS_STATUS, 32'h1);
        rd(OFS_STATUS, 32'h0);
        irq_chk(1'b0);
        // Below-threshold condition
        wr(OFS_MODE, 32'h5);
        fin(10'h1fc, 1'b1);
        catch_start(4'h1);
        irq_chk(1'b1);
        wr(OFS_MASK, 32'h0);
        irq_chk(1'b0);
        wr(OFS_MASK, 32'h1);
        irq_chk(1'b1);
        // Disable with a conversion in flight
        wr(OFS_MODE, 32'h0);
        fin(10'h000, 1'b0);
        idle_chk();
        rd(OFS_STATUS, 32'h1);
        // Scan mode over inputs zero to two
        wr(OFS_CHSEL, 32'h2);
        wr(OFS_MODE, 32'h3);
        catch_start(4'h0);
        fin(10'h3fc, 1'b1);
        catch_start(4'h1);
        fin(10'h3fc, 1'b0);
        catch_start(4'h2);
        fin(10'h3f0, 1'b0);
        catch_start(4'h0);
        fin(10'h010, 1'b0);
        catch_start(4'h1);
        rd(OFS_RESULT, 32'h010);
        rd(OFS_RESULT + 8'h04, 32'h3fc);
        rd(OFS_RESULT + 8'h08, 32'h3f0);
        rd(OFS_STATUS, 32'h3);
        wr(OFS_MODE, 32'h2);
        fin(10'h3ff, 1'b0);
        idle_chk();
        conclude();
    end
endmodule
